// >>> core/acc_ctrl.sv
// converter control: wishbone registers, power sequencing, conversion fsm
// assumes the analog core converts when conv_req_o is high and pulses
// core_done_i with its sample; wishbone inputs synchronous to clk_i
`timescale 1ns/100ps
module acc_ctrl (
	input  wire logic              clk_i,        // 100 MHz clock
	input  wire logic              rst_i,        // sync reset, high
	input  wire logic              wb_cyc_i,     // bus cycle
	input  wire logic              wb_stb_i,     // strobe
	input  wire logic              wb_we_i,      // write enable
	input  wire logic [4:0]        wb_adr_i,     // byte address
	input  wire logic [3:0]        wb_sel_i,     // byte selects
	input  wire logic [31:0]       wb_dat_i,     // write data
	output logic      [31:0]       wb_dat_o,     // read data
	output logic                   wb_ack_o,     // acknowledge
	input  wire logic              core_done_i,  // conversion finished
	input  wire logic signed [12:0] core_sample_i, // core sample
	input  wire logic              core_above_i, // above +ref
	input  wire logic              core_below_i, // below -ref
	output logic                   conv_req_o,   // convert request
	output logic                   pwr_on_o,     // analog powered
	output acc_pkg::acc_cfg_t      cfg_o,        // analog configuration
	output logic                   irq_o         // level interrupt
);
	typedef enum logic [1:0] {ST_OFF, ST_PWRUP, ST_IDLE, ST_CONV}
		acc_state_t;
	acc_state_t st_q, st_d;

	logic [7:0] ctrl0_q;
	logic [7:0] ctrl1_q;
	acc_pkg::acc_result_t res_q;
	logic [acc_pkg::IRQ_W-1:0] ist_q;
	logic [acc_pkg::IRQ_W-1:0] ien_q;
	logic [acc_pkg::CNT_W-1:0] cnt_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic req_q;
	logic pwr_q;
	acc_pkg::acc_cfg_t cfg_q;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		hit = (a[4:2] == o[4:2]);
	endfunction : hit

	wire logic       acc_go;
	wire logic       wr;
	wire logic       wr_c0;
	wire logic       wr_c1;
	wire logic       wr_en;
	wire logic       wr_clr;
	wire logic       start_wr;
	wire logic       start;
	wire logic       diff;
	wire logic       conv_end;
	wire acc_pkg::acc_result_t fmt;
	wire logic [acc_pkg::IRQ_W-1:0] ev;
	wire logic [acc_pkg::IRQ_W-1:0] clr;
	wire logic [31:0] rd;
	wire logic       idle_exp;
	wire logic       pwr_rdy;
	wire logic signed [acc_pkg::RES_W-1:0] eff;

	assign acc_go   = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr       = acc_go & wb_we_i & wb_sel_i[0];
	assign wr_c0    = wr & hit(wb_adr_i, {1'b0, acc_pkg::OFS_CTRL0});
	assign wr_c1    = wr & hit(wb_adr_i, {1'b0, acc_pkg::OFS_CTRL1});
	assign wr_en    = wr & hit(wb_adr_i, acc_pkg::OFS_IRQ_EN);
	assign wr_clr   = wr & hit(wb_adr_i, acc_pkg::OFS_IRQ_CLR);
	assign start_wr = wr_c0 & wb_dat_i[acc_pkg::C0_START_BIT];
	assign start    = ctrl0_q[acc_pkg::C0_START_BIT];
	assign diff     = ctrl1_q[acc_pkg::C1_BUF_LSB + acc_pkg::BUF_DIFF_BIT];
	assign conv_end = (st_q == ST_CONV) & core_done_i;
	assign ev       = {conv_end & fmt.ovf, conv_end};
	assign clr      = wr_clr ? wb_dat_i[acc_pkg::IRQ_W-1:0] : '0;
	assign idle_exp = (cnt_q == acc_pkg::IDLE_LAST);
	assign pwr_rdy  = (cnt_q == acc_pkg::PWRUP_LAST);
	// effective value drops the two compensation bits
	assign eff = res_q.raw[acc_pkg::RAW_W-1 -: acc_pkg::RES_W];

	acc_conv_fmt u_fmt (
		.diff_i   (diff),
		.sample_i (core_sample_i),
		.above_i  (core_above_i),
		.below_i  (core_below_i),
		.res_o    (fmt)
	);

	// read mux; result word also mirrors the 11-bit effective value
	assign rd =
		hit(wb_adr_i, {1'b0, acc_pkg::OFS_CTRL0}) ? {24'h000000, ctrl0_q} :
		hit(wb_adr_i, {1'b0, acc_pkg::OFS_CTRL1}) ? {24'h000000, ctrl1_q} :
		hit(wb_adr_i, {1'b0, acc_pkg::OFS_RESULT}) ?
			{{5{eff[acc_pkg::RES_W-1]}}, eff, res_q.raw, 2'b00, res_q.ovf} :
		hit(wb_adr_i, {1'b0, acc_pkg::OFS_STAT}) ?
			{30'h00000000, ist_q} :
		hit(wb_adr_i, acc_pkg::OFS_IRQ_EN) ? {30'h00000000, ien_q} :
		hit(wb_adr_i, acc_pkg::OFS_PWR) ?
			{28'h0000000, 2'(st_q), req_q, pwr_q} :
		32'h00000000;

	// power and conversion sequencing
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_OFF:   if (start) st_d = ST_PWRUP;
			ST_PWRUP: if (pwr_rdy) st_d = ST_CONV;
			ST_IDLE: begin
				if (start) st_d = ST_CONV;
				else if (idle_exp) st_d = ST_OFF;
			end
			ST_CONV: begin
				if (core_done_i) begin
					// single-shot shuts down; repeat keeps converting while
					// start stays set, else waits powered in ST_IDLE for a new start until the idle count expires
					if (!ctrl0_q[acc_pkg::C0_REPEAT_CONVERSION_SELECT_BIT])
						st_d = ST_OFF;
					else if (!start)
						st_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) st_q <= ST_OFF;
		else st_q <= st_d;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || st_q != st_d || st_q == ST_CONV || st_q == ST_OFF)
			cnt_q <= '0;
		else cnt_q <= cnt_q + 8'h01;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) ctrl0_q <= 8'h00;
		else if (wr_c0) ctrl0_q <= wb_dat_i[7:0];
		else if (conv_end && !ctrl0_q[acc_pkg::C0_REPEAT_CONVERSION_SELECT_BIT])
			ctrl0_q[acc_pkg::C0_START_BIT] <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) ctrl1_q <= 8'h00;
		else if (wr_c1) ctrl1_q <= wb_dat_i[7:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) res_q <= '0;
		else if (conv_end) res_q <= fmt;
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) ist_q <= '0;
		else ist_q <= (ist_q & ~clr) | ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) ien_q <= '0;
		else if (wr_en) ien_q <= wb_dat_i[acc_pkg::IRQ_W-1:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ack_q  <= acc_go;
			rdat_q <= acc_go ? rd : rdat_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_q <= 1'b0;
			pwr_q <= 1'b0;
			cfg_q <= '0;
			irq_o <= 1'b0;
		end else begin
			req_q <= (st_d == ST_CONV);
			pwr_q <= (st_d != ST_OFF);
			cfg_q.buf_mode <= ctrl1_q[acc_pkg::C1_BUF_LSB +: 3];
			cfg_q.ref_sel <= {ctrl1_q[acc_pkg::C1_REFH_BIT],
				ctrl0_q[acc_pkg::C0_REFL_BIT]};
			cfg_q.channel <= ctrl0_q[acc_pkg::C0_CH_LSB +: 4];
			cfg_q.differential <= diff;
			irq_o <= |(((ist_q & ~clr) | ev) & ien_q);
		end
	end

	assign wb_ack_o   = ack_q;
	assign wb_dat_o   = rdat_q;
	assign conv_req_o = req_q;
	assign pwr_on_o   = pwr_q;
	assign cfg_o      = cfg_q;
endmodule : acc_ctrl

// >>> core/acc_pkg.sv
// constants, register map and carrier types of the converter control block
// assumes a classic wishbone slave with 32-bit data, registers word-aligned
package acc_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_CTRL0  = 4'h0;
	localparam logic [3:0] OFS_CTRL1  = 4'h4;
	localparam logic [3:0] OFS_RESULT = 4'h8;
	localparam logic [3:0] OFS_STAT   = 4'hC;
	// second page of offsets, selected by address bit 4
	localparam logic [4:0] OFS_IRQ_EN  = 5'h10;
	localparam logic [4:0] OFS_IRQ_CLR = 5'h14;
	localparam logic [4:0] OFS_PWR     = 5'h18;
	// control 0 fields
	localparam int C0_CH_LSB   = 0;
	localparam int C0_REFL_BIT = 4;
	localparam int C0_REPEAT_CONVERSION_SELECT_BIT = 5;
	localparam int C0_START_BIT = 7;
	// control 1 fields
	localparam int C1_BUF_LSB  = 0;
	localparam int C1_REFH_BIT = 7;
	// result word: raw 13 bits in [15:3], overflow in bit 0
	localparam int RES_OVF_BIT = 0;
	localparam int RES_RAW_LSB = 3;
	localparam int RAW_W = 13;
	localparam int RES_W = 11;
	// interrupt status bits
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_OVF_BIT  = 1;
	localparam int IRQ_W = 2;
	// timing
	localparam int IDLE_CYC = 160;
	localparam int PWRUP_CYC = 40;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] IDLE_LAST  = 8'(IDLE_CYC - 1);
	localparam logic [CNT_W-1:0] PWRUP_LAST = 8'(PWRUP_CYC - 1);
	// buffer mode: bit 2 set selects differential
	localparam int BUF_DIFF_BIT = 2;

	typedef struct packed {
		logic [2:0] buf_mode;
		logic [1:0] ref_sel;
		logic [3:0] channel;
		logic       differential;
	} acc_cfg_t;

	typedef struct packed {
		logic [RAW_W-1:0] raw;
		logic             ovf;
	} acc_result_t;
endpackage : acc_pkg

// >>> core/acc_conv_fmt.sv
// formats a converter core sample into the raw result and overflow flag
// assumes the core gives a signed 13-bit sample and two range flags
`timescale 1ns/100ps
module acc_conv_fmt (
	input  wire logic                    diff_i,    // differential mode
	input  wire logic signed [12:0]      sample_i,  // core sample
	input  wire logic                    above_i,   // input above +ref
	input  wire logic                    below_i,   // input below -ref
	output acc_pkg::acc_result_t         res_o      // formatted result
);
	localparam logic signed [12:0] SE_FLOOR = 13'sh1FF0;
	wire logic ovf;
	wire logic signed [12:0] clipped;
	assign ovf = above_i | (diff_i & below_i);
	// single-ended keeps only a small negative offset margin
	assign clipped = (!diff_i && sample_i < SE_FLOOR) ? SE_FLOOR
		: sample_i;
	// invalid bits forced to zero so no reader trusts them
	// one assignment for the whole carrier keeps a single driver on it
	assign res_o = {(ovf ? 13'h0000 : clipped), ovf};
endmodule : acc_conv_fmt

// >>> sim/acc_ctrl_asserts.sv
// port timing checker for the converter control block
// assumes it is bound to acc_ctrl and sees only its ports
`timescale 1ns/100ps
module acc_ctrl_asserts (
	input wire logic              clk_i,       // clock
	input wire logic              rst_i,       // sync reset
	input wire logic              wb_cyc_i,    // bus cycle
	input wire logic              wb_stb_i,    // strobe
	input wire logic              wb_we_i,     // write
	input wire logic              wb_ack_o,    // acknowledge
	input wire logic              core_done_i, // core finished
	input wire logic              conv_req_o,  // converting
	input wire logic              pwr_on_o,    // powered
	input wire acc_pkg::acc_cfg_t cfg_o        // configuration
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// powered but idle run length; saturates so it never wraps
	logic [7:0] idle_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || !pwr_on_o || conv_req_o) idle_q <= 8'h00;
		else if (idle_q != 8'hFF) idle_q <= idle_q + 8'h01;
	end
	sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
	sequence s_wait; !conv_req_o [*8]; endsequence
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle");
	property p_why; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_why: assert property (p_why) else $error("ack without request");
	property p_pwrup;
		$rose(pwr_on_o) |-> s_wait ##[30:34] $rose(conv_req_o);
	endproperty
	a_pwrup: assert property (p_pwrup) else $error("bad power-up");
	property p_early; $rose(conv_req_o) |-> $past(pwr_on_o, 30); endproperty
	a_early: assert property (p_early) else $error("early start");
	property p_req_pwr; conv_req_o |-> pwr_on_o; endproperty
	a_req_pwr: assert property (p_req_pwr) else $error("unpowered");
	property p_idle; idle_q <= 8'hA0; endproperty
	a_idle: assert property (p_idle) else $error("idle too long");
	property p_fall;
		$fell(conv_req_o) |-> $past(core_done_i) || $past(core_done_i, 2);
	endproperty
	a_fall: assert property (p_fall) else $error("stop w/o done");
	// power drops only right after a conversion or after a full idle run
	property p_off;
		$fell(pwr_on_o) |-> !conv_req_o &&
			($past(conv_req_o) || idle_q == 8'hA0);
	endproperty
	a_off: assert property (p_off) else $error("bad shutdown");
	property p_cfg;
		!$stable(cfg_o) |-> wb_ack_o && wb_we_i || $past(wb_ack_o && wb_we_i);
	endproperty
	a_cfg: assert property (p_cfg) else $error("config w/o write");
endmodule : acc_ctrl_asserts
bind acc_ctrl acc_ctrl_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_ack_o(wb_ack_o), .core_done_i(core_done_i),
	.conv_req_o(conv_req_o), .pwr_on_o(pwr_on_o), .cfg_o(cfg_o));

// >>> sim/acc_core_model.sv
// analog core stand-in: answers a request after lat_i+1 cycles
// assumes the bench supplies {above,below,sample} and lat_i >= 1
`timescale 1ns/100ps
module acc_core_model (
	input  wire logic        clk_i, // clock
	input  wire logic        rst_i, // sync reset
	input  wire logic        req_i, // convert request
	input  wire logic [2:0]  lat_i, // answer delay
	input  wire logic [14:0] val_i, // flags and sample
	output logic             done_o, // sample valid pulse
	output logic [14:0]      val_o  // flags and sample
);
	logic [2:0] n_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || !req_i || done_o) n_q <= 3'h0;
		else n_q <= n_q + 3'h1;
		done_o <= !rst_i && req_i && !done_o && n_q == lat_i;
	end
	// outside the valid pulse the lines show garbage, never the sample
	assign val_o = done_o ? val_i : ~val_i;
endmodule : acc_core_model

// >>> sim/adc_conversion_control_tb.sv
// self-checking bench: wishbone master, core model, single-shot runs and a repeat-mode idle power-down run
// assumes acc_ctrl, acc_core_model and the bound checker
`timescale 1ns/100ps
module adc_conversion_control_tb;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, done, req, pwr;
	logic irq, ack, d, ab, be, rh, rl;
	logic [4:0] adr = 0;
	logic [31:0] dat = 0, q, rdat;
	logic [2:0] lat = 1, bm;
	logic [14:0] cv_in = 0, cv;
	logic [15:0] lf = 16'h0017, v, w;
	logic [12:0] s;
	logic [3:0] ch;
	logic [1:0] en;
	logic [12:0] cs [4] = '{13'h0FFF, 13'h1000, 13'h1F9C, 13'h0555};
	logic [4:0] ra [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h14, 5'h1C};
	acc_pkg::acc_cfg_t cfg;
	int n_fail = 0, comparisons = 0, n_cyc;
	always #5 clk_i = ~clk_i;
	acc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .core_done_i(done),
		.core_sample_i(cv[12:0]), .core_above_i(cv[14]),
		.core_below_i(cv[13]), .conv_req_o(req), .pwr_on_o(pwr),
		.cfg_o(cfg), .irq_o(irq));
	acc_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.lat_i(lat), .val_i(cv_in), .done_o(done), .val_o(cv));
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction : rnd
	// overflow zeroes the raw field; single-ended clips at -16
	function automatic logic [31:0] exp_res(logic df, logic [12:0] x,
			logic ov);
		logic [12:0] r;
		r = ov ? 13'h0000 : (!df && $signed(x) < -16) ? 13'h1FF0 : x;
		return {{5{r[12]}}, r[12:2], r, 2'b00, ov};
	endfunction : exp_res
	task automatic chk(input logic [31:0] sn, input logic [31:0] ex);
		comparisons++;
		if (sn !== ex) begin
			n_fail++;
			$display("[ERR] %0t seen %h exp %h", $time, sn, ex);
		end
	endtask : chk
	task automatic results();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	task automatic wb(input logic [4:0] a, input logic wr,
			input logic [31:0] dt);
		int k;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, wr, a, dt};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat;
		{cyc, stb} <= 2'b00;
		if (ack !== 1'b1) begin
			n_fail++;
			results();
		end
	endtask : wb
	task automatic rd(input logic [4:0] a, input logic [31:0] ex);
		wb(a, 1'b0, 32'h0);
		chk(q, ex);
	endtask : rd
	task automatic wt(input logic lv);
		int k;
		for (k = 0; req !== lv && k < 200; k++) @(posedge clk_i);
		if (req !== lv) begin
			n_fail++;
			results();
		end
	endtask : wt
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		wb(5'h0C, 1'b1, 32'hFF);
		for (int i = 0; i < 6; i++) rd(ra[i], 32'h0);
		$display("reset and refusal test done");
		for (int i = 0; i < 12; i++) begin
			v = rnd();
			w = rnd();
			d = i < 4 ? i == 1 : v[0];
			ab = i == 3 || i > 3 && &v[3:1];
			be = i > 3 && &v[6:4];
			s = i < 4 ? cs[i] : w[12:0];
			{bm, rh, rl, ch, en} = {d, v[8:7], v[9], v[10], v[14:11], {2{v[15]}}};
			lat <= v[2:0] | 3'h1;
			cv_in <= {ab, be, s};
			wb(5'h10, 1'b1, {30'h0, en});
			rd(5'h10, {30'h0, en});
			wb(5'h04, 1'b1, {24'h0, rh, 4'h0, bm});
			rd(5'h04, {24'h0, rh, 4'h0, bm});
			wb(5'h00, 1'b1, {24'h0, 3'b100, rl, ch});
			wt(1'b1);
			chk(cfg, {bm, rh, rl, ch, d});
			chk(pwr, 1'b1);
			wt(1'b0);
			@(posedge clk_i);
			chk(pwr, 1'b0);
			rd(5'h00, {27'h0, rl, ch});
			rd(5'h08, exp_res(d, s, ab | d & be));
			rd(5'h0C, {30'h0, ab | d & be, 1'b1});
			chk(irq, en[0]);
			wb(5'h14, 1'b1, 32'h3);
			rd(5'h0C, 32'h0);
			chk(irq, 1'b0);
			$display("conversion %0d done", i);
		end
		// repeat mode, then clearing start parks the converter powered
		wb(5'h00, 1'b1, 32'hA0);
		wt(1'b1);
		rd(5'h18, 32'hF);
		wb(5'h00, 1'b1, 32'h20);
		wt(1'b0);
		for (n_cyc = 0; pwr === 1'b1 && n_cyc < 400; n_cyc++)
			@(posedge clk_i);
		chk(n_cyc, acc_pkg::IDLE_CYC);
		rd(5'h18, 32'h0);
		$display("idle power-down test done");
		results();
	end
endmodule : adc_conversion_control_tb
